// >>> hdl/lcb_defs.svh
// Constants of the line interface coefficient bank.
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH

// Register bus widths.
`define LCB_IDX_W       6
`define LCB_WORD_W      16

// Indirect register indices.
`define LCB_IDX_FIRST   6'h0D
`define LCB_IDX_T1_FREQ 6'h0D
`define LCB_IDX_T1_AMPL 6'h0E
`define LCB_IDX_T1_PHAS 6'h0F
`define LCB_IDX_T2_FREQ 6'h10
`define LCB_IDX_T2_AMPL 6'h11
`define LCB_IDX_T2_PHAS 6'h12
`define LCB_IDX_RG_OFFS 6'h13
`define LCB_IDX_RG_FREQ 6'h14
`define LCB_IDX_RG_AMPL 6'h15
`define LCB_IDX_RG_PHAS 6'h16
`define LCB_IDX_MT_RAMP 6'h17
`define LCB_IDX_MT_AMPL 6'h18
`define LCB_IDX_MT_FREQ 6'h19
`define LCB_IDX_RX_GAIN 6'h1A
`define LCB_IDX_TX_GAIN 6'h1B
`define LCB_IDX_LC_HIGH 6'h1C
`define LCB_IDX_RT_THR  6'h1D
`define LCB_IDX_CM_LOW  6'h1E
`define LCB_IDX_CM_HIGH 6'h1F
`define LCB_IDX_PA_A    6'h20
`define LCB_IDX_PA_B    6'h21
`define LCB_IDX_PA_C    6'h22
`define LCB_IDX_LC_FILT 6'h23
`define LCB_IDX_RT_FILT 6'h24
`define LCB_IDX_TP_A    6'h25
`define LCB_IDX_TP_B    6'h26
`define LCB_IDX_TP_C    6'h27
`define LCB_IDX_CM_BIAS 6'h28
`define LCB_IDX_OV_VOLT 6'h29
`define LCB_IDX_RSVD    6'h2A
`define LCB_IDX_LC_LOW  6'h2B
`define LCB_IDX_LAST    6'h2B

// Field widths, all fields sit at bit 0.
`define LCB_W4          4
`define LCB_W6          6
`define LCB_W8          8
`define LCB_W12         12
`define LCB_W13         13

// Gain scale: mute, unity and the product shift for unity.
`define LCB_GAIN_MUTE   12'h000
`define LCB_GAIN_UNITY  12'h400
`define LCB_GAIN_SHIFT  10
`define LCB_PROD_W      28
`define LCB_SAT_MAX     28'sh0007FFF
`define LCB_SAT_MIN     28'shFFF8000
`define LCB_WORD_MAX    16'h7FFF
`define LCB_WORD_MIN    16'h8000
`define LCB_WORD_ZERO   16'h0000

`endif

// >>> hdl/lcb_pkg.sv
// Types of the line interface coefficient bank.
package lcb_pkg;
`include "lcb_defs.svh"

  // Register index, register word and signed gain field.
  typedef logic        [`LCB_IDX_W-1:0]  lcb_idx_t;
  typedef logic signed [`LCB_WORD_W-1:0] lcb_word_t;
  typedef logic signed [`LCB_W12-1:0]    lcb_gain_t;
endpackage : lcb_pkg

// >>> hdl/lcb_gain_if.sv
// Link between the bank and one gain multiplier.
`timescale 1ns/1ps
interface lcb_gain_if;
  import lcb_pkg::*;
  lcb_word_t sample;
  logic      sampleValid;
  lcb_gain_t gain;
  lcb_word_t result;
  logic      resultValid;

  modport src  (output sample, output sampleValid, output gain,
                input result, input resultValid);
  modport unit (input sample, input sampleValid, input gain,
                output result, output resultValid);
endinterface : lcb_gain_if

// >>> hdl/lcb_gain_mul.sv
// Signed sample by gain multiplier with saturation, one cycle latency.
`timescale 1ns/1ps
module lcb_gain_mul
  import lcb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  lcb_gain_if.unit gi
);
`include "lcb_defs.svh"

  logic signed [`LCB_PROD_W-1:0] prodFull;
  logic signed [`LCB_PROD_W-1:0] prodScaled;
  lcb_word_t                     satWord;

  // Multiply, scale so that the unity code passes samples unchanged.
  always_comb begin
    prodFull   = sample_ext(gi.sample) * gain_ext(gi.gain);
    prodScaled = prodFull >>> `LCB_GAIN_SHIFT;
    if (prodScaled > `LCB_SAT_MAX) begin
      satWord = `LCB_WORD_MAX;
    end else if (prodScaled < `LCB_SAT_MIN) begin
      satWord = `LCB_WORD_MIN;
    end else begin
      satWord = prodScaled[`LCB_WORD_W-1:0];
    end
  end

  // Sign extension helpers keep the product at full width.
  function automatic logic signed [`LCB_PROD_W-1:0] sample_ext(
    input lcb_word_t s);
    sample_ext = `LCB_PROD_W'(s);
  endfunction : sample_ext

  function automatic logic signed [`LCB_PROD_W-1:0] gain_ext(
    input lcb_gain_t g);
    gain_ext = `LCB_PROD_W'(g);
  endfunction : gain_ext

  // Register the result and its valid flag.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gi.result      <= `LCB_WORD_ZERO;
      gi.resultValid <= 1'b0;
    end else begin
      gi.result      <= gi.sampleValid ? satWord : gi.result;
      gi.resultValid <= gi.sampleValid;
    end
  end
endmodule : lcb_gain_mul

// >>> hdl/lcb_coeff_bank.sv
// Indirect coefficient bank of a telephone line interface.
//
// Behaviour
// - Coefficient words have no reset and hold garbage until written.
// - Every stored value is used as a two's-complement number.
// - Tone one takes frequency, amplitude, phase from words 13 to 15.
// - Tone two takes frequency, amplitude, phase from words 16 to 18.
// - Word 19 gives the ringing dc offset, 0 to 94.5 V by 1.5 V.
// - Ringing takes frequency, amplitude, phase from words 20 to 22.
// - Metering ramps its envelope at the rate held in word 23.
// - Metering takes amplitude from word 24 and frequency from 25.
// - Receive samples are multiplied by the receive gain before DAC.
// - Gain zero mutes, 0x400 is unity and 0x7FF gives 6 dB.
// - Transmit samples are multiplied by the transmit gain after ADC.
`timescale 1ns/1ps
module lcb_coeff_bank
  import lcb_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic [`LCB_IDX_W-1:0] regAddr,
  input  wire logic [`LCB_WORD_W-1:0] regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [`LCB_WORD_W-1:0] regRdata,
  output lcb_word_t                 tone1Freq,
  output lcb_word_t                 tone1Ampl,
  output lcb_word_t                 tone1Phase,
  output lcb_word_t                 tone2Freq,
  output lcb_word_t                 tone2Ampl,
  output lcb_word_t                 tone2Phase,
  output logic signed [`LCB_W6-1:0] ringDcOffset,
  output lcb_word_t                 ringFreq,
  output lcb_word_t                 ringAmpl,
  output lcb_word_t                 ringPhase,
  output lcb_word_t                 meterRampRate,
  output lcb_word_t                 meterAmpl,
  output lcb_word_t                 meterFreq,
  output logic signed [`LCB_W6-1:0] loopCloseHigh,
  output logic signed [`LCB_W6-1:0] loopCloseLow,
  output logic signed [`LCB_W6-1:0] ringTripThresh,
  output logic signed [`LCB_W6-1:0] commonModeLow,
  output logic signed [`LCB_W6-1:0] commonModeHigh,
  output logic signed [`LCB_W8-1:0] powerAlarmA,
  output logic signed [`LCB_W8-1:0] powerAlarmB,
  output logic signed [`LCB_W8-1:0] powerAlarmC,
  output logic signed [`LCB_W13-1:0] loopCloseFilt,
  output logic signed [`LCB_W13-1:0] ringTripFilt,
  output logic signed [`LCB_W13-1:0] thermalPoleA,
  output logic signed [`LCB_W13-1:0] thermalPoleB,
  output logic signed [`LCB_W13-1:0] thermalPoleC,
  output logic signed [`LCB_W4-1:0] ringCmBias,
  output logic signed [`LCB_W4-1:0] overheadVolt,
  input  lcb_word_t                 rxSample,
  input  wire logic                 rxValid,
  output lcb_word_t                 rxOut,
  output logic                      rxOutValid,
  input  lcb_word_t                 txSample,
  input  wire logic                 txValid,
  output lcb_word_t                 txOut,
  output logic                      txOutValid
);
`include "lcb_defs.svh"

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------

  // One word per index; data words carry no reset.
  lcb_word_t bankQ [`LCB_IDX_FIRST:`LCB_IDX_LAST];
  logic      addrMapped;
  lcb_word_t rdSel;

  // An index inside the bank that is not the reserved slot.
  assign addrMapped = (regAddr >= `LCB_IDX_FIRST) &&
                      (regAddr <= `LCB_IDX_LAST) &&
                      (regAddr != `LCB_IDX_RSVD);

  // Each data word loads on a write strobe that names its index.
  for (genvar i = `LCB_IDX_FIRST; i <= `LCB_IDX_LAST; i++) begin : gWord
    if (i == `LCB_IDX_RSVD) begin : gRsvd
      // The reserved slot holds zero and ignores writes.
      always_ff @(posedge sys_clk) begin
        bankQ[i] <= `LCB_WORD_ZERO;
      end
    end else begin : gData
      // All 16 bits are kept, so unused bits read back as written.
      always_ff @(posedge sys_clk) begin
        if (regWr && (regAddr == `LCB_IDX_W'(i))) begin
          bankQ[i] <= regWdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------

  // Select the addressed word; unmapped and reserved indices read zero.
  always_comb begin
    rdSel = `LCB_WORD_ZERO;
    if (addrMapped) begin
      rdSel = bankQ[regAddr];
    end
  end

  // Read data stand for the one cycle after the read strobe only.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= `LCB_WORD_ZERO;
    end else if (regRd) begin
      regRdata <= rdSel;
    end else begin
      regRdata <= `LCB_WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator coefficients
  // ----------------------------------------------------------------------

  // Tone generators read three consecutive words each.
  assign tone1Freq  = bankQ[`LCB_IDX_T1_FREQ];
  assign tone1Ampl  = bankQ[`LCB_IDX_T1_AMPL];
  assign tone1Phase = bankQ[`LCB_IDX_T1_PHAS];
  assign tone2Freq  = bankQ[`LCB_IDX_T2_FREQ];
  assign tone2Ampl  = bankQ[`LCB_IDX_T2_AMPL];
  assign tone2Phase = bankQ[`LCB_IDX_T2_PHAS];

  // Ringing offset step is 1.5 V, so code 63 gives 94.5 V.
  assign ringDcOffset = bankQ[`LCB_IDX_RG_OFFS][`LCB_W6-1:0];
  assign ringFreq     = bankQ[`LCB_IDX_RG_FREQ];
  assign ringAmpl     = bankQ[`LCB_IDX_RG_AMPL];
  assign ringPhase    = bankQ[`LCB_IDX_RG_PHAS];

  // Metering ramp rate, amplitude, then frequency.
  assign meterRampRate = bankQ[`LCB_IDX_MT_RAMP];
  assign meterAmpl     = bankQ[`LCB_IDX_MT_AMPL];
  assign meterFreq     = bankQ[`LCB_IDX_MT_FREQ];

  // ----------------------------------------------------------------------
  // Line control fields
  // ----------------------------------------------------------------------

  // Thresholds, filter coefficients and bias fields, signed at bit 0.
  assign loopCloseHigh  = bankQ[`LCB_IDX_LC_HIGH][`LCB_W6-1:0];
  assign loopCloseLow   = bankQ[`LCB_IDX_LC_LOW][`LCB_W6-1:0];
  assign ringTripThresh = bankQ[`LCB_IDX_RT_THR][`LCB_W6-1:0];
  assign commonModeLow  = bankQ[`LCB_IDX_CM_LOW][`LCB_W6-1:0];
  assign commonModeHigh = bankQ[`LCB_IDX_CM_HIGH][`LCB_W6-1:0];
  assign powerAlarmA    = bankQ[`LCB_IDX_PA_A][`LCB_W8-1:0];
  assign powerAlarmB    = bankQ[`LCB_IDX_PA_B][`LCB_W8-1:0];
  assign powerAlarmC    = bankQ[`LCB_IDX_PA_C][`LCB_W8-1:0];
  assign loopCloseFilt  = bankQ[`LCB_IDX_LC_FILT][`LCB_W13-1:0];
  assign ringTripFilt   = bankQ[`LCB_IDX_RT_FILT][`LCB_W13-1:0];
  assign thermalPoleA   = bankQ[`LCB_IDX_TP_A][`LCB_W13-1:0];
  assign thermalPoleB   = bankQ[`LCB_IDX_TP_B][`LCB_W13-1:0];
  assign thermalPoleC   = bankQ[`LCB_IDX_TP_C][`LCB_W13-1:0];
  assign ringCmBias     = bankQ[`LCB_IDX_CM_BIAS][`LCB_W4-1:0];
  assign overheadVolt   = bankQ[`LCB_IDX_OV_VOLT][`LCB_W4-1:0];

  // ----------------------------------------------------------------------
  // Gain paths
  // ----------------------------------------------------------------------

  lcb_gain_if rxIf ();
  lcb_gain_if txIf ();
  lcb_gain_t  rxGain;
  lcb_gain_t  txGain;

  // Both gain fields use the same scale, unity at code 0x400.
  assign rxGain = bankQ[`LCB_IDX_RX_GAIN][`LCB_W12-1:0];
  assign txGain = bankQ[`LCB_IDX_TX_GAIN][`LCB_W12-1:0];

  // Receive samples go through the gain ahead of the converter.
  assign rxIf.sample      = rxSample;
  assign rxIf.sampleValid = rxValid;
  assign rxIf.gain        = rxGain;
  assign rxOut            = rxIf.result;
  assign rxOutValid       = rxIf.resultValid;

  // Transmit samples go through the gain after the converter.
  assign txIf.sample      = txSample;
  assign txIf.sampleValid = txValid;
  assign txIf.gain        = txGain;
  assign txOut            = txIf.result;
  assign txOutValid       = txIf.resultValid;

  lcb_gain_mul uRxGain (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .gi      (rxIf.unit)
  );

  lcb_gain_mul uTxGain (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .gi      (txIf.unit)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  // A write followed by a read of the same word returns the write data.
  write_readback_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (regWr && addrMapped) ##1 (regRd && !regWr &&
      regAddr == $past(regAddr))
    |=> regRdata == $past(regWdata, 2))
    else $error("Read after write returned other data.");

  // Reserved and unmapped indices read as zero.
  unmapped_read_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regRd && !addrMapped |=> regRdata == `LCB_WORD_ZERO)
    else $error("Unmapped index did not read zero.");

  // Read data are zero in every cycle not after a read strobe.
  read_idle_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !regRd |=> regRdata == `LCB_WORD_ZERO)
    else $error("Read data stood outside their cycle.");

  // Tone one frequency follows a write to its index.
  tone1_freq_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T1_FREQ |=> tone1Freq == $past(regWdata))
    else $error("Tone one frequency did not load.");

  // Tone one amplitude and phase follow writes to their indices.
  tone1_ampl_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T1_AMPL |=> tone1Ampl == $past(regWdata))
    else $error("Tone one amplitude did not load.");

  tone1_phase_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T1_PHAS |=> tone1Phase == $past(regWdata))
    else $error("Tone one phase did not load.");

  // Tone two frequency and amplitude follow writes to their indices.
  tone2_freq_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T2_FREQ |=> tone2Freq == $past(regWdata))
    else $error("Tone two frequency did not load.");

  tone2_ampl_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T2_AMPL |=> tone2Ampl == $past(regWdata))
    else $error("Tone two amplitude did not load.");

  // Tone two phase follows a write to its index.
  tone2_phase_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_T2_PHAS |=> tone2Phase == $past(regWdata))
    else $error("Tone two phase did not load.");

  // Ringing offset takes the low six bits of its word.
  ring_offset_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_RG_OFFS
    |=> ringDcOffset == $past(regWdata[`LCB_W6-1:0]))
    else $error("Ringing offset did not load.");

  // Ringing amplitude follows a write to its index.
  ring_ampl_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_RG_AMPL |=> ringAmpl == $past(regWdata))
    else $error("Ringing amplitude did not load.");

  // Ringing frequency and phase follow writes to their indices.
  ring_freq_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_RG_FREQ |=> ringFreq == $past(regWdata))
    else $error("Ringing frequency did not load.");

  ring_phase_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_RG_PHAS |=> ringPhase == $past(regWdata))
    else $error("Ringing phase did not load.");

  // Metering ramp rate, frequency and amplitude load from their own indices.
  meter_ramp_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_MT_RAMP
    |=> meterRampRate == $past(regWdata))
    else $error("Metering ramp rate did not load.");

  meter_freq_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_MT_FREQ |=> meterFreq == $past(regWdata))
    else $error("Metering frequency did not load.");

  meter_ampl_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_MT_AMPL |=> meterAmpl == $past(regWdata))
    else $error("Metering amplitude did not load.");

  // Lower loop closure threshold takes the low six bits of its word.
  loop_low_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regWr && regAddr == `LCB_IDX_LC_LOW
    |=> loopCloseLow == $past(regWdata[`LCB_W6-1:0]))
    else $error("Lower loop closure threshold did not load.");

  // Unity receive gain passes a sample unchanged after one cycle.
  rx_unity_gain_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rxValid && rxGain == `LCB_GAIN_UNITY
    |=> rxOutValid && rxOut == $past(rxSample))
    else $error("Receive unity gain altered the sample.");

  // Zero transmit gain mutes the path.
  tx_mute_gain_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    txValid && txGain == `LCB_GAIN_MUTE
    |=> txOutValid && txOut == `LCB_WORD_ZERO)
    else $error("Transmit mute gain did not mute.");

  // Zero receive gain mutes the path.
  rx_mute_gain_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rxValid && rxGain == `LCB_GAIN_MUTE
    |=> rxOutValid && rxOut == `LCB_WORD_ZERO)
    else $error("Receive mute gain did not mute.");

  // Unity transmit gain passes a sample unchanged after one cycle.
  tx_unity_gain_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    txValid && txGain == `LCB_GAIN_UNITY
    |=> txOutValid && txOut == $past(txSample))
    else $error("Transmit unity gain altered the sample.");

  // Without a new sample the gain outputs keep their last result.
  gain_out_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !rxValid && !txValid |=> $stable(rxOut) && $stable(txOut))
    else $error("Gain output changed without a sample.");

  // Output valid flags mark only cycles after an input sample.
  gain_valid_pair_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rxOutValid == $past(rxValid) && txOutValid == $past(txValid))
    else $error("Gain output valid out of step.");

endmodule : lcb_coeff_bank

// >>> verif/lcb_coeff_bank_bench.sv
// Self-checking testbench of the line interface coefficient bank.
`timescale 1ns/1ps
module lcb_coeff_bank_bench
  import lcb_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        sys_clk;
  logic        rstn;
  logic [5:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  lcb_word_t   tone1Freq, tone1Ampl, tone1Phase;
  lcb_word_t   tone2Freq, tone2Ampl, tone2Phase;
  lcb_word_t   ringFreq, ringAmpl, ringPhase;
  lcb_word_t   meterRampRate, meterAmpl, meterFreq;
  logic [5:0]  ringDcOffset, loopCloseHigh, loopCloseLow;
  logic [5:0]  ringTripThresh, commonModeLow, commonModeHigh;
  logic [7:0]  powerAlarmA, powerAlarmB, powerAlarmC;
  logic [12:0] loopCloseFilt, ringTripFilt;
  logic [12:0] thermalPoleA, thermalPoleB, thermalPoleC;
  logic [3:0]  ringCmBias, overheadVolt;
  lcb_word_t   rxSample, rxOut, txSample, txOut;
  logic        rxValid, rxOutValid, txValid, txOutValid;
  int          num_errors;
  int          check_count;

  lcb_coeff_bank u_lcb_coeff_bank (.*);

  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  // Free-running 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle write; the write is taken at the second edge.
  task automatic wr(input logic [5:0] idx, input logic [15:0] data);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= idx;
    regWdata <= data;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  // One-cycle read; data is sampled in the single cycle it stands.
  task automatic rd(input logic [5:0] idx, output logic [15:0] data);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= idx;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 data = regRdata;
  endtask : rd

  // Field width of each mapped word, fields sit at bit 0.
  function automatic int fw(input logic [5:0] idx);
    case (idx)
      6'h13, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h2B: fw = 6;
      6'h20, 6'h21, 6'h22:                      fw = 8;
      6'h1A, 6'h1B:                             fw = 12;
      6'h23, 6'h24, 6'h25, 6'h26, 6'h27:        fw = 13;
      6'h28, 6'h29:                             fw = 4;
      default:                                  fw = 16;
    endcase
  endfunction : fw

  // Output port that carries each mapped word but the two gains, zero extended.
  function automatic logic [15:0] get_out(input logic [5:0] idx);
    case (idx)
      6'h0D: get_out = tone1Freq;
      6'h0E: get_out = tone1Ampl;
      6'h0F: get_out = tone1Phase;
      6'h10: get_out = tone2Freq;
      6'h11: get_out = tone2Ampl;
      6'h12: get_out = tone2Phase;
      6'h13: get_out = {10'h000, ringDcOffset};
      6'h14: get_out = ringFreq;
      6'h15: get_out = ringAmpl;
      6'h16: get_out = ringPhase;
      6'h17: get_out = meterRampRate;
      6'h18: get_out = meterAmpl;
      6'h19: get_out = meterFreq;
      6'h1C: get_out = {10'h000, loopCloseHigh};
      6'h1D: get_out = {10'h000, ringTripThresh};
      6'h1E: get_out = {10'h000, commonModeLow};
      6'h1F: get_out = {10'h000, commonModeHigh};
      6'h20: get_out = {8'h00, powerAlarmA};
      6'h21: get_out = {8'h00, powerAlarmB};
      6'h22: get_out = {8'h00, powerAlarmC};
      6'h23: get_out = {3'h0, loopCloseFilt};
      6'h24: get_out = {3'h0, ringTripFilt};
      6'h25: get_out = {3'h0, thermalPoleA};
      6'h26: get_out = {3'h0, thermalPoleB};
      6'h27: get_out = {3'h0, thermalPoleC};
      6'h28: get_out = {12'h000, ringCmBias};
      6'h29: get_out = {12'h000, overheadVolt};
      default: get_out = {10'h000, loopCloseLow};
    endcase
  endfunction : get_out

  // Signed product, scaled so that 0x400 is unity, saturated.
  function automatic logic [15:0] gmul(input logic signed [15:0] s,
                                       input logic signed [11:0] g);
    int p;
    p = s * g;
    p = p >>> 10;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction : gmul

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Every mapped word twice with inverted patterns: readback, and port for all but the gains.
  task automatic test_bank();
    logic [15:0] d, r;
    logic [16:0] m;
    for (int p = 0; p < 2; p++) begin
      for (int i = 13; i <= 43; i++) begin
        if (i == 42) continue;
        m = (17'h00001 << fw(6'(i))) - 17'h00001;
        d = ({2'b10, 6'(i), 2'b01, 6'(i)} ^ {16{p[0]}}) & m[15:0];
        wr(6'(i), d);
        #1;
        if (i != 26 && i != 27)
          chk($sformatf("port of word %0d", i), get_out(6'(i)),
              d & m[15:0]);
        rd(6'(i), r);
        chk($sformatf("readback %0d", i), r, d);
        @(posedge sys_clk);
        #1 chk("idle read data", regRdata, 16'h0000);
      end
    end
  endtask : test_bank

  // Write then two reads with no gap between the strobes.
  task automatic test_back2back();
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= 6'h0E;
    regWdata <= 16'hBEEF;
    @(posedge sys_clk);
    regWr   <= 1'b0;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regAddr <= 6'h18;
    #1 chk("read after write", regRdata, 16'hBEEF);
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk("second read", regRdata, 16'h67A7);
    @(posedge sys_clk);
    #1 chk("read data drop", regRdata, 16'h0000);
  endtask : test_back2back

  // Reserved and unmapped indices ignore writes and read as zero.
  task automatic test_unmapped();
    logic [5:0]  bad [5] = '{6'h00, 6'h0C, 6'h2A, 6'h2C, 6'h3F};
    logic [15:0] r;
    foreach (bad[k]) begin
      wr(bad[k], 16'hFFFF);
      rd(bad[k], r);
      chk($sformatf("unmapped %0d", bad[k]), r, 16'h0000);
    end
    chk("tone1 amplitude kept", tone1Ampl, 16'hBEEF);
  endtask : test_unmapped

  // Both gain paths over mute, unity, maximum and negative codes.
  task automatic test_gain();
    logic [11:0] g [5] = '{12'h000, 12'h400, 12'h7FF, 12'h800, 12'h200};
    logic [15:0] s [4] = '{16'h1234, 16'h8000, 16'h7FFF, 16'hC001};
    for (int k = 0; k < 5; k++) begin
      wr(6'h1A, {4'h0, g[k]});
      wr(6'h1B, {4'h0, g[4-k]});
      for (int i = 0; i <= 4; i++) begin
        @(posedge sys_clk);
        rxValid <= (i < 4);
        txValid <= (i < 4);
        rxSample <= s[i%4];
        txSample <= s[3-(i%4)];
        #1;
        chk("rx valid", {15'h0, rxOutValid}, {15'h0, i > 0});
        chk("tx valid", {15'h0, txOutValid}, {15'h0, i > 0});
        if (i > 0) begin
          chk("rx out", rxOut, gmul(s[i-1], g[k]));
          chk("tx out", txOut, gmul(s[4-i], g[4-k]));
        end
      end
      @(posedge sys_clk);
      #1 chk("rx valid end", {15'h0, rxOutValid}, 16'h0000);
    end
  endtask : test_gain

  // Reset in mid-run clears the sample outputs at once.
  task automatic test_reset_again();
    @(posedge sys_clk);
    rstn <= 1'b0;
    #1;
    chk("rx out in reset", rxOut, 16'h0000);
    chk("tx out in reset", txOut, 16'h0000);
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask : test_reset_again

  task automatic report_and_stop();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Resets the bank, then runs each scenario in turn.
  initial begin
    num_errors  = 0;
    check_count = 0;
    rstn     = 1'b0;
    regAddr  = 6'h00;
    regWdata = 16'h0000;
    regWr    = 1'b0;
    regRd    = 1'b0;
    rxSample = 16'h0000;
    txSample = 16'h0000;
    rxValid  = 1'b0;
    txValid  = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("read data in reset", regRdata, 16'h0000);
    @(posedge sys_clk);
    rstn <= 1'b1;
    test_bank();
    test_back2back();
    test_unmapped();
    test_gain();
    test_reset_again();
    test_gain();
    report_and_stop();
  end
endmodule : lcb_coeff_bank_bench
